// ---- inc/mmad_map.svh ----
// Offsets, field positions, reset values and vectors of the address decoder.
`ifndef MMAD_MAP_SVH
`define MMAD_MAP_SVH

`define MMAD_IDX_INDIRECT   7'h00
`define MMAD_IDX_PC_LOW     7'h02
`define MMAD_IDX_STATUS     7'h03
`define MMAD_IDX_POINTER    7'h04
`define MMAD_IDX_PCLATCH    7'h0a
`define MMAD_IDX_INTCTL     7'h0b
`define MMAD_GPR_FIRST      7'h20
`define MMAD_GPR_LAST       7'h5f

`define MMAD_BANK_BIT       5
`define MMAD_RES_HI_BIT     6
`define MMAD_RES_IND_BIT    7

`define MMAD_STATUS_RST     8'h18
`define MMAD_STATUS_WMASK   8'he7
`define MMAD_POINTER_RST    8'h00
`define MMAD_PCLATCH_RST    5'h00
`define MMAD_INTCTL_RST     8'h00

`define MMAD_RESET_VECTOR   13'h0000
`define MMAD_IRQ_VECTOR     13'h0004

`define MMAD_DATA_SPAN      12'h200
`define MMAD_OWN_PC_ADDR    12'h200
`define MMAD_OWN_LAST_ADDR  12'h204

`define MMAD_RESP_OKAY      2'b00
`define MMAD_RESP_SLVERR    2'b10

`endif

// ---- inc/mmad_pkg.sv ----
// Types shared by the address decoder and its storage.
package mmad_pkg;

    typedef enum logic [2:0] {
        MMAD_TGT_NONE    = 3'b000,
        MMAD_TGT_GPR     = 3'b001,
        MMAD_TGT_PC_LOW  = 3'b010,
        MMAD_TGT_STATUS  = 3'b011,
        MMAD_TGT_POINTER = 3'b100,
        MMAD_TGT_PCLATCH = 3'b101,
        MMAD_TGT_INTCTL  = 3'b110
    } mmad_target_e;

    typedef struct packed {
        mmad_target_e target;
        logic [5:0]   gpr_idx;
    } mmad_dec_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } mmad_wbeat_s;

endpackage

// ---- rtl/mmad_gpr_ram.sv ----
// General-purpose byte file: static storage, one write port, one read port.
`timescale 1ns/1ps
module mmad_gpr_ram
    import mmad_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int WIDTH = 8,
    parameter int AW    = 6
) (
    input  wire logic             aclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    // The cells hold their contents with no refresh and no reset.
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule

// ---- rtl/mmad_top.sv ----
// Program and data memory address decoder with an AXI4-Lite register port.
//
// Operation
// RQ1: Program counter is 13 bits, addressing 8K words of 14 bits.
// RQ2: Only program words 0000h to 03FFh physically exist.
// RQ3: Fetches above 1K wrap; counter bits above bit 9 are ignored.
// RQ4: After reset the first fetch is from address 0000h.
// RQ5: A taken interrupt loads the program counter with 0004h.
// RQ6: Two data banks; lowest 32 locations of each are special registers.
// RQ7: Locations 20h-5Fh are shared RAM; bank 1 A0h-DFh aliases them.
// RQ8: Locations with nothing behind them read as zero.
// RQ9: Status bit 5 selects bank 0 or bank 1 for direct access.
// RQ10: Software keeps status bits 7 and 6 at zero.
// RQ11: The 64-byte file is reachable directly and through the pointer.
// RQ12: Special register storage is static and needs no refresh.
// RQ13: Direct address is bank bit on top of the 7-bit field.
// RQ14: Location zero redirects to the pointer address; no storage there.
// RQ15: Core registers sit at the same offset in both banks.
`timescale 1ns/1ps
`include "mmad_map.svh"
module mmad_top
    import mmad_pkg::*;
#(
    parameter int PC_W    = 13,
    parameter int FETCH_W = 10,
    parameter int GPR_N   = 64,
    parameter int AXI_AW  = 12
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [AXI_AW-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               irq_take,
    input  wire logic               pc_advance,
    output logic [FETCH_W-1:0]      fetch_addr,
    output logic [PC_W-1:0]         pc_value,
    output logic                    bank_select_bit
);

    logic [PC_W-1:0]      pc;
    logic [PC_W-1:0]      next_pc;
    logic [7:0]           status_flags;
    logic [7:0]           indirect_pointer;
    logic [4:0]           program_counter_upper_latch;
    logic [7:0]           interrupt_control;
    logic                 aw_held;
    logic                 w_held;
    logic                 next_aw_held;
    logic                 next_w_held;
    logic                 next_bvalid;
    logic                 next_rvalid;
    logic                 wr_fire;
    logic                 ar_fire;
    mmad_wbeat_s          wbeat;
    mmad_dec_s            wr_dec;
    mmad_dec_s            rd_dec;
    logic                 wr_in_data;
    logic                 rd_in_data;
    logic                 wr_mapped;
    logic                 rd_mapped;
    logic                 wr_lane0;
    logic                 pc_load;
    logic                 ram_we;
    logic [7:0]           ram_rdata;
    logic [7:0]           rd_byte;
    logic [31:0]          next_rdata;

    // Turns the 7-bit field into a target, resolving location zero first.
    function automatic mmad_dec_s decode_file(input logic [6:0] field,
                                              input logic       bank,
                                              input logic [7:0] pointer);
        logic [7:0] addr8;
        logic [6:0] low;
        mmad_dec_s  dec;
        addr8 = {bank, field};                                   // RQ13 RQ9
        if (field == `MMAD_IDX_INDIRECT) begin
            addr8 = pointer;                                     // RQ14 RQ11
        end
        low = addr8[6:0];
        dec.target  = MMAD_TGT_NONE;                             // RQ8
        dec.gpr_idx = 6'h00;
        if (low >= `MMAD_GPR_FIRST && low <= `MMAD_GPR_LAST) begin
            dec.target  = MMAD_TGT_GPR;                          // RQ7
            dec.gpr_idx = 6'(low - `MMAD_GPR_FIRST);
        end else begin
            // Bank bit is dropped here, so both banks see one copy.
            case (low)                                           // RQ6 RQ15
                `MMAD_IDX_PC_LOW:  dec.target = MMAD_TGT_PC_LOW;
                `MMAD_IDX_STATUS:  dec.target = MMAD_TGT_STATUS;
                `MMAD_IDX_POINTER: dec.target = MMAD_TGT_POINTER;
                `MMAD_IDX_PCLATCH: dec.target = MMAD_TGT_PCLATCH;
                `MMAD_IDX_INTCTL:  dec.target = MMAD_TGT_INTCTL;
                default:           dec.target = MMAD_TGT_NONE;   // RQ8 RQ14
            endcase
        end
        return dec;
    endfunction

    // Write channel: address and data are taken in either order.
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_bvalid  = s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // Readies are set from the next state, so a held half is never taken
    // twice and nothing is taken while the answer stands.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_bvalid  <= next_bvalid;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
        end
    end

    // Each half of the write is kept here until the other has arrived.
    // The register update then works from this copy, not from the bus.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wbeat <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wbeat.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wbeat.data <= s_axi_wdata;
                wbeat.strb <= s_axi_wstrb;
            end
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored.
    assign wr_in_data = wbeat.addr < `MMAD_DATA_SPAN;
    assign wr_mapped  = wr_in_data
                        || wbeat.addr == `MMAD_OWN_PC_ADDR
                        || wbeat.addr == `MMAD_OWN_LAST_ADDR;
    assign wr_lane0   = wr_fire && wr_in_data && wbeat.strb[0];
    assign wr_dec     = decode_file(wbeat.addr[8:2],
                                    status_flags[`MMAD_BANK_BIT],
                                    indirect_pointer);
    assign pc_load    = wr_lane0 && wr_dec.target == MMAD_TGT_PC_LOW;
    assign ram_we     = wr_lane0 && wr_dec.target == MMAD_TGT_GPR;

    // Addresses past the data space and the own registers are refused
    // with an error response; the write itself is dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= `MMAD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= wr_mapped ? `MMAD_RESP_OKAY : `MMAD_RESP_SLVERR;
        end
    end

    // Core special registers keep their values until written or reset.
    always_ff @(posedge aclk) begin                              // RQ12
        if (!aresetn) begin
            status_flags <= `MMAD_STATUS_RST;
        end else if (wr_lane0 && wr_dec.target == MMAD_TGT_STATUS) begin
            // Reserved upper bits are stored as written; software keeps them 0.
            status_flags <= (wbeat.data[7:0] & `MMAD_STATUS_WMASK)
                            | (status_flags & ~`MMAD_STATUS_WMASK); // RQ10
        end
    end

    // The pointer holds a whole 8-bit file address, so an indirect access
    // reaches either bank whatever the bank bit says.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            indirect_pointer <= `MMAD_POINTER_RST;
        end else if (wr_lane0 && wr_dec.target == MMAD_TGT_POINTER) begin
            indirect_pointer <= wbeat.data[7:0];
        end
    end

    // Only five latch bits exist; the upper three read as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_counter_upper_latch <= `MMAD_PCLATCH_RST;
        end else if (wr_lane0 && wr_dec.target == MMAD_TGT_PCLATCH) begin
            program_counter_upper_latch <= wbeat.data[4:0];
        end
    end

    // Interrupt control is plain storage; no bit of it is set by hardware.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_control <= `MMAD_INTCTL_RST;
        end else if (wr_lane0 && wr_dec.target == MMAD_TGT_INTCTL) begin
            interrupt_control <= wbeat.data[7:0];
        end
    end

    // Program counter: interrupt beats a low-byte write, which beats a step.
    always_comb begin
        next_pc = pc;
        if (irq_take) begin
            next_pc = `MMAD_IRQ_VECTOR;                          // RQ5
        end else if (pc_load) begin
            next_pc = {program_counter_upper_latch, wbeat.data[7:0]};
        end else if (pc_advance) begin
            next_pc = PC_W'(pc + 1'b1);                          // RQ1
        end
    end

    // The fetch address keeps only the low counter bits, so a fetch above
    // the implemented range wraps into it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc         <= `MMAD_RESET_VECTOR;                    // RQ4
            fetch_addr <= '0;                                    // RQ4
            pc_value   <= `MMAD_RESET_VECTOR;
        end else begin
            pc         <= next_pc;
            fetch_addr <= next_pc[FETCH_W-1:0];                  // RQ3 RQ2
            pc_value   <= next_pc;
        end
    end

    // The bank bit is shown one cycle behind the status register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_select_bit <= 1'b0;
        end else begin
            bank_select_bit <= status_flags[`MMAD_BANK_BIT];     // RQ9
        end
    end

    // Read channel: the answer is registered one edge after the address.
    assign ar_fire    = s_axi_arvalid && s_axi_arready;
    assign rd_in_data = s_axi_araddr < `MMAD_DATA_SPAN;
    assign rd_mapped  = rd_in_data
                        || s_axi_araddr == `MMAD_OWN_PC_ADDR
                        || s_axi_araddr == `MMAD_OWN_LAST_ADDR;
    assign rd_dec     = decode_file(s_axi_araddr[8:2],
                                    status_flags[`MMAD_BANK_BIT],
                                    indirect_pointer);

    // One byte file serves both banks; it is written from the held beat
    // and read from the address on the read channel.
    mmad_gpr_ram #(
        .DEPTH (GPR_N),
        .WIDTH (8),
        .AW    (6)
    ) u_gpr (
        .aclk  (aclk),
        .we    (ram_we),                                         // RQ11
        .waddr (wr_dec.gpr_idx),
        .wdata (wbeat.data[7:0]),
        .raddr (rd_dec.gpr_idx),
        .rdata (ram_rdata)
    );

    // The read decode picks which storage drives the read byte.
    always_comb begin
        case (rd_dec.target)
            MMAD_TGT_GPR:     rd_byte = ram_rdata;               // RQ7
            MMAD_TGT_PC_LOW:  rd_byte = pc[7:0];
            MMAD_TGT_STATUS:  rd_byte = status_flags;
            MMAD_TGT_POINTER: rd_byte = indirect_pointer;
            MMAD_TGT_PCLATCH: rd_byte = {3'h0, program_counter_upper_latch};
            MMAD_TGT_INTCTL:  rd_byte = interrupt_control;
            default:          rd_byte = 8'h00;                   // RQ8
        endcase
    end

    // The own registers sit above the data space and are read-only; the
    // counter word carries the fetch address and the full counter.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_in_data) begin
            next_rdata = {24'h00_0000, rd_byte};
        end else if (s_axi_araddr == `MMAD_OWN_PC_ADDR) begin
            next_rdata = {6'h00, fetch_addr, 3'h0, pc};          // RQ3
        end else if (s_axi_araddr == `MMAD_OWN_LAST_ADDR) begin
            next_rdata = {24'h00_0000, 7'h00, bank_select_bit};
        end
    end

    // A read answer stands until taken; no address is accepted meanwhile.
    always_comb begin
        next_rvalid = s_axi_rvalid;
        if (ar_fire) begin
            next_rvalid = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= !next_rvalid;
        end
    end

    // Data and response are captured at the address handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MMAD_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_mapped ? `MMAD_RESP_OKAY : `MMAD_RESP_SLVERR;
        end
    end

endmodule

// ---- tb/mmad_top_asserts.sv ----
// Concurrent checks on the ports of the address decoder.
`timescale 1ns/1ps
module mmad_top_asserts
    import mmad_pkg::*;
#(
    parameter int PC_W    = 13,
    parameter int FETCH_W = 10,
    parameter int AXI_AW  = 12
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic [AXI_AW-1:0]  s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               irq_take,
    input wire logic               pc_advance,
    input wire logic [FETCH_W-1:0] fetch_addr,
    input wire logic [PC_W-1:0]    pc_value
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_hs;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    reset_outputs_a: assert property (disable iff (1'b0)
        !aresetn |=> pc_value == '0 && fetch_addr == '0 && !s_axi_bvalid
        && !s_axi_rvalid) else $error("outputs not cleared by reset");
    irq_vector_a: assert property (
        irq_take |=> pc_value == PC_W'(4))
        else $error("pc not at interrupt vector");
    pc_step_a: assert property (
        pc_advance && !irq_take |=> pc_value == PC_W'($past(pc_value) + 1)
        || s_axi_bvalid)
        else $error("pc did not step by one");
    fetch_wrap_a: assert property (
        fetch_addr == pc_value[FETCH_W-1:0])
        else $error("fetch address not low pc bits");
    data_upper_zero_a: assert property (
        ar_hs && s_axi_araddr < 'h200 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("data read has upper bits set");
    unimpl_zero_a: assert property (
        ar_hs && s_axi_araddr < 'h200 && s_axi_araddr[8:7] == 2'b11
        |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'b00)
        else $error("unimplemented location not zero");
    unmapped_err_a: assert property (
        ar_hs && s_axi_araddr >= 'h208
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    read_excl_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("address accepted during read answer");
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule

bind mmad_top mmad_top_asserts #(.PC_W(PC_W), .FETCH_W(FETCH_W),
    .AXI_AW(AXI_AW)) mmad_top_asserts_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .irq_take(irq_take),
    .pc_advance(pc_advance), .fetch_addr(fetch_addr), .pc_value(pc_value));

// ---- tb/testbench.sv ----
// Self-checking bench for the address decoder.
`timescale 1ns/1ps
module testbench
    import mmad_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        irq_take = 1'b0;
    logic        pc_advance = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, bank_select_bit;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [9:0]  fetch_addr;
    logic [12:0] pc_value;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    mmad_top mmad_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_take(irq_take),
        .pc_advance(pc_advance), .fetch_addr(fetch_addr),
        .pc_value(pc_value), .bank_select_bit(bank_select_bit));

    always #5 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic pulse(input logic irq);
        @(posedge aclk);
        irq_take   <= irq;
        pc_advance <= !irq;
        @(posedge aclk);
        irq_take   <= 1'b0;
        pc_advance <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_reset;
        check(pc_value, 13'h0000);
        check(fetch_addr, 10'h000);
        rd(12'h00c);
        check(d, 32'h0000_0018);
        check(bank_select_bit, 1'b0);
    endtask

    task automatic t_pc;
        pulse(1'b1);
        check(pc_value, 13'h0004);
        wr(12'h028, 8'h1f);
        wr(12'h008, 8'hff);
        repeat (2) @(posedge aclk);
        check(pc_value, 13'h1fff);
        check(fetch_addr, 10'h3ff);
        pulse(1'b0);
        check(pc_value, 13'h0000);
        wr(12'h028, 8'h04);
        wr(12'h008, 8'h05);
        rd(12'h200);
        check(d, {6'h0, 10'h005, 3'h0, 13'h0405});
        rd(12'h008);
        check(d, 32'h0000_0005);
        rd(12'h028);
        check(d, 32'h0000_0004);
    endtask

    task automatic t_bank;
        wr(12'h080, 8'h5a);
        wr(12'h17c, 8'ha5);
        wr(12'h00c, 8'h20);
        rd(12'h00c);
        check(d, 32'h0000_0038);
        check(bank_select_bit, 1'b1);
        rd(12'h204);
        check(d, 32'h0000_0001);
        rd(12'h080);
        check(d, 32'h0000_005a);
        rd(12'h17c);
        check(d, 32'h0000_00a5);
        wr(12'h02c, 8'hc3);
        rd(12'h02c);
        check(d, 32'h0000_00c3);
        wr(12'h010, 8'hdf);
        rd(12'h000);
        check(d, 32'h0000_00a5);
        wr(12'h000, 8'h3c);
        rd(12'h17c);
        check(d, 32'h0000_003c);
        wr(12'h010, 8'h80);
        rd(12'h000);
        check(d, 32'h0);
        wr(12'h00c, 8'h00);
        rd(12'h010);
        check(d, 32'h0000_0080);
    endtask

    task automatic t_unimpl;
        wr(12'h004, 8'h55);
        for (int f = 1; f < 128; f++) begin
            if (!(f inside {2, 3, 4, 10, 11, [32:95]})) begin
                rd(12'(f * 4));
                check(d, 32'h0);
                check(r, 2'b00);
            end
        end
        rd(12'h208);
        check(r, 2'b10);
        wr(12'h20c, 8'h01);
        check(r, 2'b10);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_pc;
        t_bank;
        t_unimpl;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        end_of_test;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test;
        end
    end
endmodule
